/* verilog/dram_cfg_pkg.sv */
// package: register map, field layout, reset values and latency constants
package dram_cfg_pkg;
  localparam logic [11:0] CH0_TERM_OFF     = 12'h29C;
  localparam logic [11:0] CH1_RB0_OFF      = 12'h600;
  localparam logic [11:0] CH1_RB1_OFF      = 12'h602;
  localparam logic [11:0] CH1_ATTR_OFF     = 12'h608;
  localparam logic [11:0] CH1_PCHG_OFF     = 12'h650;
  localparam logic [31:0] CH0_TERM_RST     = 32'h00100000;
  localparam logic [15:0] CH1_RB0_RST      = 16'h0000;
  localparam logic [15:0] CH1_RB1_RST      = 16'h0000;
  localparam logic [15:0] CH1_ATTR_RST     = 16'h0000;
  localparam logic [15:0] CH1_PCHG_RST     = 16'h0000;
  localparam int          TERM_LAT_LSB     = 20;
  localparam int          COL_LAT_LSB      = 17;
  localparam int          ACT_PCHG_LSB     = 11;
  localparam int          WR_PCHG_LSB      = 6;
  localparam int          RD_PCHG_LSB      = 2;
  localparam int          PCHG_PCHG_LSB    = 0;
  localparam logic [3:0]  TERM_LAT_MIN     = 4'h1;
  localparam logic [3:0]  TERM_LAT_MAX     = 4'hC;
  localparam logic [3:0]  COL_LAT_BASE     = 4'h3;
  localparam logic [31:0] CH0_TERM_WMASK   = 32'h00FE0000;
  localparam logic [15:0] CH1_RB_WMASK     = 16'h03FF;
endpackage

/* verilog/dram_channel_timing_termination_config.sv */
// config slice: termination/column latency and channel 1 precharge spacing tracker
`timescale 1ns/1ps
// What this block does
// RQ1: termination asserted programmed clocks after chip select
// RQ2: column latency is code plus three clocks
// RQ3: rank top boundary is topmost populated address
// RQ4: software programs boundaries cumulative over rank three
// RQ5: two attribute bytes, rank one upper byte
// RQ6: precharge waits activate-to-precharge gap
// RQ7: precharge waits write-to-precharge gap
// RQ8: precharge waits read-to-precharge gap
// RQ9: successive same-rank precharges spaced by gap
// RQ10: trackers hold pending precharge until gaps met
module dram_channel_timing_termination_config #(
  parameter int RANKS = 2,
  parameter int BANKS = 8
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [11:0]              reg_addr_i,
  input  wire logic [31:0]              reg_wdata_i,
  output logic      [31:0]              reg_rdata_o,
  input  wire logic                     cs_i,
  output logic                          term_en_o,
  output logic      [3:0]               column_access_latency_o,
  output logic      [9:0]               ch1_rank_top_boundary_zero_o,
  output logic      [9:0]               ch1_rank_top_boundary_one_o,
  output logic      [7:0]               ch1_rank_attribute_byte_zero_o,
  output logic      [7:0]               ch1_rank_attribute_byte_one_o,
  input  wire logic                     cmd_act_i,
  input  wire logic                     cmd_wr_i,
  input  wire logic                     cmd_rd_i,
  input  wire logic [$clog2(RANKS)-1:0] cmd_rank_i,
  input  wire logic [$clog2(BANKS)-1:0] cmd_bank_i,
  input  wire logic                     pchg_req_i,
  input  wire logic [$clog2(RANKS)-1:0] pchg_rank_i,
  input  wire logic [$clog2(BANKS)-1:0] pchg_bank_i,
  output logic                          pchg_grant_o,
  output logic                          pchg_wait_o
);
  localparam int RB = RANKS * BANKS;
  // the tracker index is rank and bank side by side, so both must be powers of two
  if (RANKS < 2 || BANKS < 2
      || (RANKS & (RANKS - 1)) != 0 || (BANKS & (BANKS - 1)) != 0) begin : g_bad_geometry
    $error("ranks and banks must be powers of two, each at least two");
  end

  typedef struct packed {
    logic [31:0]        term_ctl;
    logic [15:0]        rb0;
    logic [15:0]        rb1;
    logic [15:0]        attr;
    logic [15:0]        pchg;
    logic [31:0]        rdata;
    logic [15:0]        cs_hist;
    logic               term;
    logic [RB-1:0][4:0] act_cnt;
    logic [RB-1:0][4:0] wr_cnt;
    logic [RB-1:0][3:0] rd_cnt;
    logic [RANKS-1:0][1:0] pp_cnt;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] term_lat;
  logic [4:0] act_gap;
  logic [4:0] wr_gap;
  logic [3:0] rd_gap;
  logic [1:0] pp_gap;
  // flat tracker index: rank in the upper bits, bank in the lower bits
  logic [$clog2(RB)-1:0] pidx;
  logic [$clog2(RB)-1:0] cidx;
  logic       pchg_ok;

  assign term_lat = s_q.term_ctl[dram_cfg_pkg::TERM_LAT_LSB +: 4];
  assign act_gap  = s_q.pchg[dram_cfg_pkg::ACT_PCHG_LSB +: 5];
  assign wr_gap   = s_q.pchg[dram_cfg_pkg::WR_PCHG_LSB +: 5];
  assign rd_gap   = s_q.pchg[dram_cfg_pkg::RD_PCHG_LSB +: 4];
  assign pp_gap   = s_q.pchg[dram_cfg_pkg::PCHG_PCHG_LSB +: 2];
  assign pidx     = {pchg_rank_i, pchg_bank_i};
  assign cidx     = {cmd_rank_i, cmd_bank_i};

  // a counter saturates at its field maximum, which no gap exceeds, so "count >= gap" means the spacing is met
  assign pchg_ok = (s_q.act_cnt[pidx] >= act_gap) // RQ6
                && (s_q.wr_cnt[pidx] >= wr_gap)    // RQ7
                && (s_q.rd_cnt[pidx] >= rd_gap)    // RQ8
                && (s_q.pp_cnt[pchg_rank_i] >= pp_gap); // RQ9
  assign pchg_grant_o = pchg_req_i && pchg_ok; // RQ10
  assign pchg_wait_o  = pchg_req_i && !pchg_ok; // RQ10

  always_comb begin
    s_d = s_q;
    // registers
    if (reg_wr_i) begin
      case (reg_addr_i)
        dram_cfg_pkg::CH0_TERM_OFF: s_d.term_ctl = reg_wdata_i & dram_cfg_pkg::CH0_TERM_WMASK;
        dram_cfg_pkg::CH1_RB0_OFF:  s_d.rb0 = reg_wdata_i[15:0] & dram_cfg_pkg::CH1_RB_WMASK; // RQ3
        dram_cfg_pkg::CH1_RB1_OFF:  s_d.rb1 = reg_wdata_i[15:0] & dram_cfg_pkg::CH1_RB_WMASK; // RQ3
        dram_cfg_pkg::CH1_ATTR_OFF: s_d.attr = reg_wdata_i[15:0]; // RQ5
        dram_cfg_pkg::CH1_PCHG_OFF: s_d.pchg = reg_wdata_i[15:0];
        default: ;
      endcase
    end
    s_d.rdata = 32'h00000000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        dram_cfg_pkg::CH0_TERM_OFF: s_d.rdata = s_q.term_ctl;
        dram_cfg_pkg::CH1_RB0_OFF:  s_d.rdata = {16'h0000, s_q.rb0};
        dram_cfg_pkg::CH1_RB1_OFF:  s_d.rdata = {16'h0000, s_q.rb1};
        dram_cfg_pkg::CH1_ATTR_OFF: s_d.rdata = {16'h0000, s_q.attr};
        dram_cfg_pkg::CH1_PCHG_OFF: s_d.rdata = {16'h0000, s_q.pchg};
        default:                    s_d.rdata = 32'h00000000;
      endcase
    end
    // termination delay line: bit k = chip select seen k+1 clocks ago
    s_d.cs_hist = {s_q.cs_hist[14:0], cs_i};
    // reserved codes leave termination off rather than guess a latency
    if (term_lat >= dram_cfg_pkg::TERM_LAT_MIN && term_lat <= dram_cfg_pkg::TERM_LAT_MAX) begin
      s_d.term = s_q.cs_hist[term_lat - 4'h1]; // RQ1
    end else begin
      s_d.term = 1'b0;
    end
    // elapsed-clock trackers, saturating at the field maximum
    // saturation keeps an idle bank ready forever without a wider counter
    for (int i = 0; i < RB; i++) begin
      if (s_q.act_cnt[i] != 5'h1F) s_d.act_cnt[i] = s_q.act_cnt[i] + 5'h01; // RQ10
      if (s_q.wr_cnt[i] != 5'h1F)  s_d.wr_cnt[i]  = s_q.wr_cnt[i] + 5'h01;
      if (s_q.rd_cnt[i] != 4'hF)   s_d.rd_cnt[i]  = s_q.rd_cnt[i] + 4'h1;
    end
    for (int r = 0; r < RANKS; r++) begin
      if (s_q.pp_cnt[r] != 2'h3) s_d.pp_cnt[r] = s_q.pp_cnt[r] + 2'h1;
    end
    // a command restarts its tracker; count 1 on the next clock is one clock elapsed
    if (cmd_act_i) s_d.act_cnt[cidx] = 5'h01; // RQ6
    if (cmd_wr_i)  s_d.wr_cnt[cidx]  = 5'h01; // RQ7
    if (cmd_rd_i)  s_d.rd_cnt[cidx]  = 4'h1;  // RQ8
    if (pchg_grant_o) s_d.pp_cnt[pchg_rank_i] = 2'h1; // RQ9
    if (!rst_n_i) begin
      s_d = '0;
      s_d.term_ctl = dram_cfg_pkg::CH0_TERM_RST;
      s_d.rb0 = dram_cfg_pkg::CH1_RB0_RST;
      s_d.rb1 = dram_cfg_pkg::CH1_RB1_RST;
      s_d.attr = dram_cfg_pkg::CH1_ATTR_RST;
      s_d.pchg = dram_cfg_pkg::CH1_PCHG_RST;
      s_d.act_cnt = '1;
      s_d.wr_cnt = '1;
      s_d.rd_cnt = '1;
      s_d.pp_cnt = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  assign reg_rdata_o                    = s_q.rdata;
  assign term_en_o                      = s_q.term;
  assign column_access_latency_o        = {1'b0, s_q.term_ctl[dram_cfg_pkg::COL_LAT_LSB +: 3]}
                                          + dram_cfg_pkg::COL_LAT_BASE; // RQ2
  assign ch1_rank_top_boundary_zero_o   = s_q.rb0[9:0]; // RQ3
  assign ch1_rank_top_boundary_one_o    = s_q.rb1[9:0];
  assign ch1_rank_attribute_byte_zero_o = s_q.attr[7:0]; // RQ5
  assign ch1_rank_attribute_byte_one_o  = s_q.attr[15:8]; // RQ5

  ////////////////////////////////////////////////////////////////////////
  // spacing checks look two clocks after the command, when its tracker reads two
  a_act_gap_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ6
    cmd_act_i && act_gap > 5'h2 ##2 pchg_req_i && pchg_rank_i == $past(cmd_rank_i, 2)
      && pchg_bank_i == $past(cmd_bank_i, 2) |-> !pchg_grant_o)
    else $error("precharge granted too soon after activate");
  a_wr_gap_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ7
    cmd_wr_i && wr_gap > 5'h2 ##2 pchg_req_i && pchg_rank_i == $past(cmd_rank_i, 2)
      && pchg_bank_i == $past(cmd_bank_i, 2) |-> !pchg_grant_o)
    else $error("precharge granted inside write recovery");
  a_rd_gap_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ8
    cmd_rd_i && rd_gap > 4'h2 ##2 pchg_req_i && pchg_rank_i == $past(cmd_rank_i, 2)
      && pchg_bank_i == $past(cmd_bank_i, 2) |-> !pchg_grant_o)
    else $error("precharge granted inside read gap");
  a_pp_gap_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ9
    pchg_grant_o && pp_gap == 2'h3 ##2 pchg_req_i && pchg_rank_i == $past(pchg_rank_i, 2)
      |-> !pchg_grant_o)
    else $error("precharges to one rank too close");
  a_pchg_wait_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ10
    pchg_req_i |-> pchg_grant_o ^ pchg_wait_o)
    else $error("pending precharge neither granted nor held");
  a_term_one_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
    term_lat == 4'h1 && $stable(term_lat) ##0 cs_i ##2 $stable(term_lat) |-> term_en_o)
    else $error("termination not asserted after one clock");
  a_term_twelve_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
    term_lat == 4'hC && $stable(term_lat) ##0 cs_i ##13 $stable(term_lat) |-> term_en_o)
    else $error("termination not asserted after twelve clocks");
  a_term_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
    term_lat == 4'h0 ##1 term_lat == 4'h0 |-> !term_en_o)
    else $error("termination asserted on reserved code");
  a_col_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
    reg_wr_i && reg_addr_i == dram_cfg_pkg::CH0_TERM_OFF |=>
      column_access_latency_o == {1'b0, $past(reg_wdata_i[dram_cfg_pkg::COL_LAT_LSB +: 3])} + 4'h3)
    else $error("column latency not code plus three");
  a_attr_bytes: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
    reg_wr_i && reg_addr_i == dram_cfg_pkg::CH1_ATTR_OFF |=>
      ch1_rank_attribute_byte_one_o == $past(reg_wdata_i[15:8]))
    else $error("rank one attribute not in upper byte");
  a_attr_low_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
    reg_wr_i && reg_addr_i == dram_cfg_pkg::CH1_ATTR_OFF |=>
      ch1_rank_attribute_byte_zero_o == $past(reg_wdata_i[7:0]))
    else $error("rank zero attribute not in lower byte");
  a_boundary_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
    reg_wr_i && reg_addr_i == dram_cfg_pkg::CH1_RB0_OFF |=>
      ch1_rank_top_boundary_zero_o == $past(reg_wdata_i[9:0]))
    else $error("rank top boundary not stored");
  a_boundary_one_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
    reg_wr_i && reg_addr_i == dram_cfg_pkg::CH1_RB1_OFF |=>
      ch1_rank_top_boundary_one_o == $past(reg_wdata_i[9:0]))
    else $error("second rank top boundary not stored");
  c_pchg_stall: cover property (@(posedge clk_i) disable iff (!rst_n_i) pchg_wait_o ##1 pchg_grant_o);
  c_term_on:    cover property (@(posedge clk_i) disable iff (!rst_n_i) cs_i ##[1:12] term_en_o);
  c_wr_then_pchg: cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_wr_i ##[1:31] pchg_grant_o);
  c_rd_then_pchg: cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_rd_i ##[1:15] pchg_grant_o);
  c_term_reserved: cover property (@(posedge clk_i) disable iff (!rst_n_i) term_lat == 4'hD ##0 cs_i);
endmodule // dram_channel_timing_termination_config

/* verif/dram_rank_model.sv */
// model of the channel 1 ranks: tallies the precharges that reach them
`timescale 1ns/1ps
module dram_rank_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       pchg_grant_i,
  output logic      [7:0] pchg_count_o
);
  // a grant is the issue itself, so each granted edge is one precharge on the wire
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pchg_count_o <= 8'h00;
    end else if (pchg_grant_i) begin
      pchg_count_o <= pchg_count_o + 8'h01;
    end
  end
endmodule // dram_rank_model

/* verif/dram_channel_timing_termination_config_tb_top.sv */
// testbench: register access, termination delay and channel 1 precharge spacing
`timescale 1ns/1ps
module dram_channel_timing_termination_config_tb_top;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, cs_i = 1'b0;
  logic        cmd_act_i = 1'b0, cmd_wr_i = 1'b0, cmd_rd_i = 1'b0, pchg_req_i = 1'b0;
  logic [0:0]  cmd_rank_i = 1'b0, pchg_rank_i = 1'b0;
  logic [2:0]  cmd_bank_i = 3'h0, pchg_bank_i = 3'h0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic        term_en_o, pchg_grant_o, pchg_wait_o;
  logic [3:0]  column_access_latency_o, tn [4] = '{4'h1, 4'hC, 4'h0, 4'hD};
  logic [2:0]  tc [4] = '{3'h0, 3'h7, 3'h3, 3'h5};
  logic [9:0]  ch1_rank_top_boundary_zero_o, ch1_rank_top_boundary_one_o;
  logic [7:0]  ch1_rank_attribute_byte_zero_o, ch1_rank_attribute_byte_one_o, pchg_count;
  int          num_errors = 0, samples_checked = 0;

  always #12.5 clk_i = ~clk_i;

  dram_channel_timing_termination_config #(.RANKS(2), .BANKS(8)) u_dut (.clk_i, .rst_n_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cs_i, .term_en_o, .column_access_latency_o,
    .ch1_rank_top_boundary_zero_o, .ch1_rank_top_boundary_one_o, .ch1_rank_attribute_byte_zero_o,
    .ch1_rank_attribute_byte_one_o, .cmd_act_i, .cmd_wr_i, .cmd_rd_i, .cmd_rank_i, .cmd_bank_i,
    .pchg_req_i, .pchg_rank_i, .pchg_bank_i, .pchg_grant_o, .pchg_wait_o);
  dram_rank_model u_ranks (.clk_i, .rst_n_i, .pchg_grant_i(pchg_grant_o), .pchg_count_o(pchg_count));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step;
    @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    step();
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    step();
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    step();
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    step();
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, e);
  endtask
  // kind 0..2 = activate, write, read; kind 3 = an earlier granted precharge
  task automatic pt(input int k, input int gap, input int lsb);
    wr(dram_cfg_pkg::CH1_PCHG_OFF, 32'(gap) << lsb);
    repeat (4) step();
    cmd_act_i = (k == 0);
    cmd_wr_i = (k == 1);
    cmd_rd_i = (k == 2);
    pchg_req_i = (k == 3);
    #1 if (k == 3) chk({31'h0, pchg_grant_o}, 32'h1);
    step();
    // the other rank stays free while rank 0 bank 0 runs its tracker
    {cmd_act_i, cmd_wr_i, cmd_rd_i, pchg_req_i} = 4'h1;
    pchg_rank_i = 1'b1;
    #1 chk({31'h0, pchg_grant_o}, 32'h1);
    step();
    pchg_rank_i = 1'b0;
    #1;
    for (int i = 2; i <= gap; i++) begin
      if (i > 2) step();
      chk({30'h0, pchg_grant_o, pchg_wait_o}, (i >= gap) ? 32'h2 : 32'h1);
    end
    step();
    pchg_req_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    rd(dram_cfg_pkg::CH0_TERM_OFF, dram_cfg_pkg::CH0_TERM_RST);
    rd(dram_cfg_pkg::CH1_PCHG_OFF, 32'h0);
    rd(12'h604, 32'h0);
    // boundaries climb cumulatively above channel 0's top rank; upper bits test the mask
    wr(dram_cfg_pkg::CH1_RB0_OFF, 32'hFD55);
    wr(dram_cfg_pkg::CH1_RB1_OFF, 32'h03FF);
    wr(dram_cfg_pkg::CH1_ATTR_OFF, 32'hA55A);
    rd(dram_cfg_pkg::CH1_RB0_OFF, 32'h0155);
    chk({12'h0, ch1_rank_top_boundary_one_o, ch1_rank_top_boundary_zero_o}, 32'hFFD55);
    rd(dram_cfg_pkg::CH1_ATTR_OFF, 32'hA55A);
    chk({16'h0, ch1_rank_attribute_byte_one_o, ch1_rank_attribute_byte_zero_o}, 32'hA55A);
    // limit codes 1 and 12 must assert termination; reserved codes 0 and 13 must leave it off entirely
    for (int j = 0; j < 4; j++) begin
      wr(dram_cfg_pkg::CH0_TERM_OFF, {8'hFF, tn[j], tc[j], 17'h1FFFF});
      rd(dram_cfg_pkg::CH0_TERM_OFF, {8'h00, tn[j], tc[j], 17'h0});
      chk({28'h0, column_access_latency_o}, {29'h0, tc[j]} + 32'h3);
      step();
      cs_i = 1'b1;
      step();
      cs_i = 1'b0;
      for (int i = 1; i < 15; i++) begin
        chk({31'h0, term_en_o}, {31'h0, tn[j] >= 4'h1 && tn[j] <= 4'hC && i == tn[j] + 1});
        step();
      end
    end
    pt(0, 31, dram_cfg_pkg::ACT_PCHG_LSB);
    pt(1, 7, dram_cfg_pkg::WR_PCHG_LSB);
    pt(2, 15, dram_cfg_pkg::RD_PCHG_LSB);
    pt(3, 3, dram_cfg_pkg::PCHG_PCHG_LSB);
    chk({24'h0, pchg_count}, 32'h9);
    give_verdict();
  end

  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end
endmodule // dram_channel_timing_termination_config_tb_top
